// ==== rtl/wsc_pkg.sv ====
// constants of the wake source control register bank
//
// Overview of operation
// - internal control bit 7 set makes the second cyclic timer a wake source.
// - internal control bit 6 set makes the first cyclic timer a wake source.
// - internal bit 2 disables the watchdog in stop mode; hardware may update it.
// - reserved bits of the wake control registers always read as zero.
// - external bit 7 clear: only wake events interrupt; set: every status bit.
// - external bit 5 enables measurement; wake inputs one and two stop waking.
// - external control bit 2 enables wake input three as a wake source.
// - external bit 1 enables wake input two unless measurement overrides.
// - external bit 0 enables wake input one unless measurement overrides.
// - CAN and LIN wake only when their bus mode field is wake capable.
// - fail-safe entry forces bus control xxx0 1001, external x0x0 0111.
// - power-on or soft reset gives external 0000 0111; restart x0x0 0xxx.
// - restart keeps both timer enables of internal control, clears the rest.
// - two-bit bias per input: none, pull-down, pull-up, automatic switching.
// - internal control sits at index 0x06 and resets to zero.
package wsc_pkg;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int NUM_WAKE_PINS = 3;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_BUS_CTRL = 6'h04;
  localparam logic [5:0] IDX_INT_CTRL = 6'h06;
  localparam logic [5:0] IDX_EXT_CTRL = 6'h07;
  localparam logic [5:0] IDX_BIAS = 6'h08;
  localparam logic [5:0] IDX_FILTER = 6'h09;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h0A;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h0B;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0C;
  localparam logic [5:0] IDX_LEVEL = 6'h0D;
  // writable bit masks
  localparam logic [7:0] BUS_CTRL_WMASK = 8'hFF;
  localparam logic [7:0] INT_CTRL_WMASK = 8'hC4;
  localparam logic [7:0] EXT_CTRL_WMASK = 8'hA7;
  localparam logic [7:0] BIAS_WMASK = 8'h3F;
  localparam logic [7:0] FILTER_WMASK = 8'h3F;
  // power-on and soft reset values
  localparam logic [7:0] BUS_CTRL_POR = 8'h20;
  localparam logic [7:0] INT_CTRL_POR = 8'h00;
  localparam logic [7:0] EXT_CTRL_POR = 8'h07;
  localparam logic [7:0] BIAS_POR = 8'h00;
  localparam logic [7:0] FILTER_POR = 8'h00;
  // restart: bits kept, all others cleared
  localparam logic [7:0] BUS_CTRL_RST_KEEP = 8'hFF;
  localparam logic [7:0] INT_CTRL_RST_KEEP = 8'hC0;
  localparam logic [7:0] EXT_CTRL_RST_KEEP = 8'hA7;
  localparam logic [7:0] BIAS_RST_KEEP = 8'h3F;
  localparam logic [7:0] FILTER_RST_KEEP = 8'h3F;
  // fail-safe entry: kept bits and forced pattern
  localparam logic [7:0] BUS_CTRL_FS_KEEP = 8'hE0;
  localparam logic [7:0] BUS_CTRL_FS_VAL = 8'h09;
  localparam logic [7:0] EXT_CTRL_FS_KEEP = 8'hA0;
  localparam logic [7:0] EXT_CTRL_FS_VAL = 8'h07;
  // field positions
  localparam int INT_TIMER2_EN_BIT = 7;
  localparam int INT_TIMER1_EN_BIT = 6;
  localparam int INT_WD_STOP_BIT = 2;
  localparam int EXT_IRQ_ALL_BIT = 7;
  localparam int EXT_MEASURE_BIT = 5;
  localparam logic [1:0] BUS_MODE_WAKE = 2'h1;
  // status and source enable layout
  localparam int ST_WAKE1 = 0;
  localparam int ST_WAKE2 = 1;
  localparam int ST_WAKE3 = 2;
  localparam int ST_TIMER1 = 3;
  localparam int ST_TIMER2 = 4;
  localparam int ST_CAN = 5;
  localparam int ST_LIN = 6;
  localparam int ST_OTHER = 7;
  localparam logic [7:0] WAKE_ONLY_MASK = 8'h7F;
  localparam logic [7:0] ALL_STATUS_MASK = 8'hFF;
  localparam logic [6:0] SRC_EN_POR = 7'h07;
endpackage : wsc_pkg

// ==== rtl/wsc_sync_if.sv ====
// synchronised wake pin levels and change pulses
`timescale 1ns/100ps
interface wsc_sync_if #(parameter int N = 3);
  logic [N-1:0] level;
  logic [N-1:0] change;
  modport src (output level, output change);
  modport dst (input level, input change);
endinterface : wsc_sync_if

// ==== rtl/wsc_wake_sync.sv ====
// three-stage synchroniser and change detector for wake pins
`timescale 1ns/100ps
module wsc_wake_sync #(
  parameter int N = 3
) (
  input logic pclk,
  input logic presetn,
  input logic [N-1:0] wake_pin,
  wsc_sync_if.src sync
);
  import wsc_pkg::*;

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] level;
    logic [N-1:0] change;
  } wsc_sync_s;

  wsc_sync_s s;
  wsc_sync_s next_s;
  logic [N-1:0] differ;

  // level follows the pin once stages two and three agree
  always_comb begin
    next_s = s;
    next_s.s1 = wake_pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    differ = s.s2 ^ s.s3;
    next_s.level = (s.s3 & ~differ) | (s.level & differ);
    next_s.change = next_s.level ^ s.level;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync.level = s.level;
  assign sync.change = s.change;
endmodule : wsc_wake_sync

// ==== rtl/wsc_regs.sv ====
// wake source control registers with APB slave and interrupt
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module wsc_regs (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [wsc_pkg::APB_AW-1:0] paddr,
  input logic [wsc_pkg::APB_DW-1:0] pwdata,
  input logic [3:0] pstrb,
  output logic [wsc_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [wsc_pkg::NUM_WAKE_PINS-1:0] wake_pin,
  input logic timer1_wake_evt,
  input logic timer2_wake_evt,
  input logic can_wake_evt,
  input logic lin_wake_evt,
  input logic other_status_evt,
  input logic normal_mode,
  input logic soft_reset,
  input logic restart_entry,
  input logic failsafe_entry,
  input logic wd_stop_update,
  input logic wd_stop_value,
  output logic irq,
  output logic wake_request,
  output logic [6:0] wake_source_enable,
  output logic watchdog_stop_disable_bit,
  output logic measure_active,
  output logic [1:0] wake_input_one_bias,
  output logic [1:0] wake_input_two_bias,
  output logic [1:0] wake_input_three_bias,
  output logic [5:0] filter_config,
  output logic [7:0] bus_control
);
  import wsc_pkg::*;

  typedef struct packed {
    logic [7:0] bus_ctrl;
    logic [7:0] int_ctrl;
    logic [7:0] ext_ctrl;
    logic [7:0] bias;
    logic [7:0] filter;
    logic [7:0] status;
    logic [7:0] irq_en;
    logic [6:0] src_en;
    logic [7:0] rdata;
    logic slverr;
    logic irq;
    logic wake_req;
    logic measure_on;
  } wsc_state_s;

  wsc_state_s s;
  wsc_state_s next_s;

  wsc_sync_if #(.N(NUM_WAKE_PINS)) pins ();

  wsc_wake_sync #(.N(NUM_WAKE_PINS)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .wake_pin(wake_pin),
    .sync(pins.src)
  );

  logic [5:0] idx;
  logic mapped;
  logic setup_phase;
  logic write_taken;
  logic [7:0] wbyte;
  logic [7:0] events;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] scope;
  logic [7:0] rd_mux;

  // merge writable bits only, others keep the stored value
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction : merge

  // address decode, unaligned or unknown index is an error
  always_comb begin
    idx = paddr[APB_AW-1:2];
    mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      unique case (idx)
        IDX_BUS_CTRL, IDX_INT_CTRL, IDX_EXT_CTRL, IDX_BIAS, IDX_FILTER,
        IDX_IRQ_STATUS, IDX_IRQ_CLEAR, IDX_IRQ_ENABLE, IDX_LEVEL:
          mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // read data selection, reserved bits are held at zero
  always_comb begin
    unique case (idx)
      IDX_BUS_CTRL: rd_mux = s.bus_ctrl;
      IDX_INT_CTRL: rd_mux = s.int_ctrl & INT_CTRL_WMASK;
      IDX_EXT_CTRL: rd_mux = s.ext_ctrl & EXT_CTRL_WMASK;
      IDX_BIAS: rd_mux = s.bias & BIAS_WMASK;
      IDX_FILTER: rd_mux = s.filter & FILTER_WMASK;
      IDX_IRQ_STATUS: rd_mux = s.status;
      IDX_IRQ_ENABLE: rd_mux = s.irq_en;
      IDX_LEVEL: rd_mux = {5'h00, pins.level};
      default: rd_mux = 8'h00;
    endcase
  end

  // wake events gated by the effective source enables
  always_comb begin
    events = {other_status_evt, lin_wake_evt, can_wake_evt, timer2_wake_evt,
              timer1_wake_evt, pins.change};
    set_vec = events & {1'b1, s.src_en};
  end

  // next state: bus access, hardware update, mode entries
  always_comb begin
    next_s = s;
    setup_phase = psel && !penable;
    write_taken = psel && penable && pwrite && mapped && pstrb[0];
    wbyte = pwdata[7:0];
    clr_vec = 8'h00;
    // read data and error latched in the setup cycle
    if (setup_phase) begin
      next_s.rdata = mapped ? rd_mux : 8'h00;
      next_s.slverr = !mapped;
    end
    if (write_taken) begin
      unique case (idx)
        IDX_BUS_CTRL:
          next_s.bus_ctrl = merge(s.bus_ctrl, wbyte, BUS_CTRL_WMASK);
        IDX_INT_CTRL:
          next_s.int_ctrl = merge(s.int_ctrl, wbyte, INT_CTRL_WMASK);
        IDX_EXT_CTRL:
          next_s.ext_ctrl = merge(s.ext_ctrl, wbyte, EXT_CTRL_WMASK);
        IDX_BIAS:
          next_s.bias = merge(s.bias, wbyte, BIAS_WMASK);
        IDX_FILTER:
          next_s.filter = merge(s.filter, wbyte, FILTER_WMASK);
        IDX_IRQ_CLEAR: clr_vec = wbyte;
        IDX_IRQ_ENABLE: next_s.irq_en = wbyte;
        default: next_s.irq_en = s.irq_en;
      endcase
    end
    // device side update of the stop-mode watchdog bit
    if (wd_stop_update) begin
      next_s.int_ctrl[INT_WD_STOP_BIT] = wd_stop_value;
    end
    // restart keeps only the marked bits
    if (restart_entry) begin
      next_s.bus_ctrl = s.bus_ctrl & BUS_CTRL_RST_KEEP;
      next_s.int_ctrl = s.int_ctrl & INT_CTRL_RST_KEEP;
      next_s.ext_ctrl = s.ext_ctrl & EXT_CTRL_RST_KEEP;
      next_s.bias = s.bias & BIAS_RST_KEEP;
      next_s.filter = s.filter & FILTER_RST_KEEP;
    end
    // fail-safe forces a wakeable configuration
    if (failsafe_entry) begin
      next_s.bus_ctrl = (s.bus_ctrl & BUS_CTRL_FS_KEEP) | BUS_CTRL_FS_VAL;
      next_s.ext_ctrl = (s.ext_ctrl & EXT_CTRL_FS_KEEP) | EXT_CTRL_FS_VAL;
    end
    // soft reset restores power-on values
    if (soft_reset) begin
      next_s.bus_ctrl = BUS_CTRL_POR;
      next_s.int_ctrl = INT_CTRL_POR;
      next_s.ext_ctrl = EXT_CTRL_POR;
      next_s.bias = BIAS_POR;
      next_s.filter = FILTER_POR;
    end
    // sticky status, a new event wins over a clear
    next_s.status = (s.status & ~clr_vec) | set_vec;
    // effective wake sources from the new configuration
    next_s.src_en[ST_WAKE1] = next_s.ext_ctrl[0]
                              && !next_s.ext_ctrl[EXT_MEASURE_BIT];
    next_s.src_en[ST_WAKE2] = next_s.ext_ctrl[1]
                              && !next_s.ext_ctrl[EXT_MEASURE_BIT];
    next_s.src_en[ST_WAKE3] = next_s.ext_ctrl[2];
    next_s.src_en[ST_TIMER1] = next_s.int_ctrl[INT_TIMER1_EN_BIT];
    next_s.src_en[ST_TIMER2] = next_s.int_ctrl[INT_TIMER2_EN_BIT];
    next_s.src_en[ST_CAN] = next_s.bus_ctrl[1:0] == BUS_MODE_WAKE;
    next_s.src_en[ST_LIN] = next_s.bus_ctrl[4:3] == BUS_MODE_WAKE;
    next_s.measure_on = next_s.ext_ctrl[EXT_MEASURE_BIT] && normal_mode;
    // interrupt scope, wake bits only unless all status is selected
    scope = next_s.ext_ctrl[EXT_IRQ_ALL_BIT] ? ALL_STATUS_MASK
                                              : WAKE_ONLY_MASK;
    next_s.irq = |(next_s.status & next_s.irq_en & scope);
    next_s.wake_req = |set_vec[6:0];
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.bus_ctrl <= BUS_CTRL_POR;
      s.ext_ctrl <= EXT_CTRL_POR;
      s.src_en <= SRC_EN_POR;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign prdata = {24'h000000, s.rdata};
  assign pready = psel && penable;
  assign pslverr = psel && penable && s.slverr;
  assign irq = s.irq;
  assign wake_request = s.wake_req;
  assign wake_source_enable = s.src_en;
  assign watchdog_stop_disable_bit = s.int_ctrl[INT_WD_STOP_BIT];
  assign measure_active = s.measure_on;
  assign wake_input_one_bias = s.bias[1:0];
  assign wake_input_two_bias = s.bias[3:2];
  assign wake_input_three_bias = s.bias[5:4];
  assign filter_config = s.filter[5:0];
  assign bus_control = s.bus_ctrl;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic quiet;
  assign quiet = !soft_reset && !failsafe_entry && !restart_entry;

  reserved_read_zero_a: assert property (
    pready && !pwrite && paddr == {IDX_INT_CTRL, 2'h0}
    |-> prdata[5:3] == 3'h0 && prdata[1:0] == 2'h0)
    else $error("reserved internal bits read nonzero");

  timer2_wake_a: assert property (
    timer2_wake_evt && s.int_ctrl[7] |=> s.status[ST_TIMER2] && wake_request)
    else $error("enabled second timer did not wake");

  timer1_off_a: assert property (
    !s.int_ctrl[6] && !s.status[ST_TIMER1] |=> !s.status[ST_TIMER1])
    else $error("disabled first timer set status");

  wd_stop_update_a: assert property (
    wd_stop_update && quiet
    |=> watchdog_stop_disable_bit == $past(wd_stop_value))
    else $error("watchdog stop bit not updated by device");

  irq_scope_a: assert property (
    !s.ext_ctrl[7] && s.status[6:0] == 7'h00 |-> !irq)
    else $error("non-wake status raised interrupt");

  measure_gate_a: assert property (
    s.ext_ctrl[5] |-> wake_source_enable[1:0] == 2'h0)
    else $error("inputs one and two wake while measuring");

  wake3_enable_a: assert property (
    pins.change[2] && !s.ext_ctrl[2] && !s.status[ST_WAKE3]
    |=> !s.status[ST_WAKE3])
    else $error("disabled input three set status");

  bus_wake_a: assert property (
    wake_source_enable[ST_CAN] == (s.bus_ctrl[1:0] == 2'h1)
    && wake_source_enable[ST_LIN] == (s.bus_ctrl[4:3] == 2'h1))
    else $error("bus wake enable does not follow mode field");

  failsafe_force_a: assert property (
    failsafe_entry && !soft_reset
    |=> s.bus_ctrl[4:0] == 5'h09 && (s.ext_ctrl & 8'h5F) == 8'h07)
    else $error("fail-safe pattern not applied");

  soft_reset_a: assert property (
    soft_reset |=> s.ext_ctrl == 8'h07 && s.int_ctrl == 8'h00)
    else $error("soft reset values wrong");

  restart_keep_a: assert property (
    restart_entry && !soft_reset
    |=> s.int_ctrl == ($past(s.int_ctrl) & 8'hC0))
    else $error("restart did not clear internal control");

  reserved_hold_a: assert property (
    s.bias[7:6] == 2'h0 && (s.ext_ctrl & 8'h58) == 8'h00)
    else $error("reserved bits changed by write");

  cover_failsafe_c: cover property (failsafe_entry ##1 irq);
  cover_measure_c: cover property (measure_active && pins.change[0]);
  cover_clear_race_c: cover property (
    pready && pwrite && paddr == {IDX_IRQ_CLEAR, 2'h0} && |set_vec);
  cover_restart_c: cover property (restart_entry && s.int_ctrl[7:6] != 2'h0);
endmodule : wsc_regs

// ==== verification/wsc_host_model.sv ====
// host controller model issuing register transfers on the APB port
`timescale 1ns/100ps
module wsc_host_model (
  input logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [wsc_pkg::APB_AW-1:0] paddr,
  output logic [wsc_pkg::APB_DW-1:0] pwdata,
  output logic [3:0] pstrb,
  input logic [wsc_pkg::APB_DW-1:0] prdata,
  input logic pready,
  input logic pslverr
);
  import wsc_pkg::*;

  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
  end

  // one transfer: setup, then access until pready seen at an edge
  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd,
                      output logic err, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    err = 1'b0;
    rd = 32'h00000000;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    while (!ok && n < 16) begin
      @(posedge pclk);
      n++;
      if (pready === 1'b1) begin
        ok = 1'b1;
        rd = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : wsc_host_model

// ==== verification/wake_source_control_regs_bench.sv ====
// self-checking bench for the wake source control register bank
`timescale 1ns/100ps
module wake_source_control_regs_bench;
  import wsc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [2:0] wake_pin = 3'h0;
  logic [4:0] ev = 5'h00;
  logic [3:0] md = 4'h0;
  logic normal_mode = 1'b0;
  logic wd_stop_value = 1'b0;
  logic irq, wake_request, watchdog_stop_disable_bit, measure_active, hit;
  logic [6:0] wake_source_enable;
  logic [1:0] b1, b2, b3;
  logic [5:0] filter_config;
  logic [7:0] bus_control;
  logic [5:0] ti [5] = '{IDX_INT_CTRL, IDX_EXT_CTRL, IDX_BIAS, IDX_FILTER,
                         IDX_BUS_CTRL};
  logic [7:0] te [5] = '{8'hC4, 8'hA7, 8'h3F, 8'h3F, 8'hFF};
  logic [7:0] ex [5] = '{8'h01, 8'h02, 8'h04, 8'h23, 8'h27};
  logic [7:0] en [5] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h04};
  int mismatches = 0;
  int tests_run = 0;

  always #5 pclk = ~pclk;

  wsc_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  wsc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_pin(wake_pin), .timer1_wake_evt(ev[0]), .timer2_wake_evt(ev[1]),
    .can_wake_evt(ev[2]), .lin_wake_evt(ev[3]), .other_status_evt(ev[4]),
    .normal_mode(normal_mode), .soft_reset(md[0]), .restart_entry(md[1]),
    .failsafe_entry(md[2]), .wd_stop_update(md[3]),
    .wd_stop_value(wd_stop_value), .irq(irq), .wake_request(wake_request),
    .wake_source_enable(wake_source_enable),
    .watchdog_stop_disable_bit(watchdog_stop_disable_bit),
    .measure_active(measure_active), .wake_input_one_bias(b1),
    .wake_input_two_bias(b2), .wake_input_three_bias(b3),
    .filter_config(filter_config), .bus_control(bus_control));

  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // compare seen against expected
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // register read with expected byte, and register write
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp_v);
    logic [31:0] d;
    logic ok;
    host.xfer(1'b0, idx, 8'h00, d, last_err, ok);
    if (!ok) begin
      mismatches++;
      final_report();
    end else begin
      check($sformatf("reg %h", idx), d, {24'h000000, exp_v});
    end
  endtask : rd

  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic ok;
    host.xfer(1'b1, idx, v, d, last_err, ok);
    if (!ok) begin
      mismatches++;
      final_report();
    end
  endtask : wr

  // one-cycle pulses on event and mode inputs
  task automatic pulse(input int i, input logic mode);
    @(posedge pclk);
    if (mode) md[i] <= 1'b1;
    else ev[i] <= 1'b1;
    @(posedge pclk);
    if (mode) md[i] <= 1'b0;
    else ev[i] <= 1'b0;
    #1;
  endtask : pulse

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(IDX_INT_CTRL, 8'h00);
    rd(IDX_EXT_CTRL, 8'h07);
    rd(IDX_BIAS, 8'h00);
    rd(IDX_BUS_CTRL, 8'h20);
    check("enables", wake_source_enable, 7'h07);
    $display("test reset_values finished");
    for (int i = 0; i < 5; i++) begin
      wr(ti[i], 8'hFF);
      rd(ti[i], te[i]);
    end
    settle();
    check("enables", wake_source_enable, 7'h1C);
    check("wd stop", watchdog_stop_disable_bit, 1'b1);
    check("measure", measure_active, 1'b0);
    check("filter", filter_config, 6'h3F);
    check("bus ctrl", bus_control, 8'hFF);
    normal_mode <= 1'b1;
    settle();
    check("measure", measure_active, 1'b1);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_BIAS, {2'b00, c[1:0], c[1:0], c[1:0]});
      settle();
      check("bias", {b3, b2, b1}, {3{c[1:0]}});
    end
    $display("test masks_bias finished");
    wr(IDX_INT_CTRL, 8'h00);
    wr(IDX_BUS_CTRL, 8'h20);
    for (int i = 0; i < 5; i++) begin
      wr(IDX_EXT_CTRL, ex[i]);
      settle();
      check("enables", wake_source_enable, en[i]);
    end
    wr(IDX_BUS_CTRL, 8'h09);
    settle();
    check("enables", wake_source_enable, 7'h64);
    wr(IDX_BUS_CTRL, 8'h0B);
    settle();
    check("enables", wake_source_enable, 7'h44);
    wr(IDX_BUS_CTRL, 8'h20);
    $display("test source_enables finished");
    wr(IDX_EXT_CTRL, 8'h01);
    wr(IDX_INT_CTRL, 8'hC0);
    wr(IDX_IRQ_ENABLE, 8'hFF);
    wr(IDX_IRQ_CLEAR, 8'hFF);
    pulse(1, 1'b0);
    check("wake req", wake_request, 1'b1);
    check("irq", irq, 1'b1);
    rd(IDX_IRQ_STATUS, 8'h10);
    wr(IDX_IRQ_CLEAR, 8'hFF);
    wr(IDX_INT_CTRL, 8'h00);
    pulse(0, 1'b0);
    check("wake req", wake_request, 1'b0);
    pulse(4, 1'b0);
    settle();
    check("irq", irq, 1'b0);
    rd(IDX_IRQ_STATUS, 8'h80);
    wr(IDX_EXT_CTRL, 8'h81);
    settle();
    check("irq", irq, 1'b1);
    wr(IDX_IRQ_CLEAR, 8'hFF);
    wr(IDX_EXT_CTRL, 8'h01);
    $display("test interrupts finished");
    hit = 1'b0;
    wake_pin <= 3'h1;
    for (int n = 0; n < 12 && !hit; n++) begin
      @(posedge pclk);
      #1;
      hit = (wake_request === 1'b1);
    end
    check("pin wake", hit, 1'b1);
    rd(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_EXT_CTRL, 8'h21);
    wr(IDX_IRQ_CLEAR, 8'hFF);
    wake_pin <= 3'h0;
    repeat (8) @(posedge pclk);
    rd(IDX_IRQ_STATUS, 8'h00);
    // level register still shows inputs one and two while measuring; all three pins are low
    rd(IDX_LEVEL, 8'h00);
    $display("test wake_pins finished");
    wr(IDX_INT_CTRL, 8'hC4);
    wr(IDX_EXT_CTRL, 8'hA7);
    pulse(1, 1'b1);
    rd(IDX_INT_CTRL, 8'hC0);
    rd(IDX_EXT_CTRL, 8'hA7);
    wr(IDX_EXT_CTRL, 8'hA0);
    wr(IDX_BUS_CTRL, 8'hFF);
    pulse(2, 1'b1);
    rd(IDX_BUS_CTRL, 8'hE9);
    check("bus ctrl", bus_control, 8'hE9);
    rd(IDX_EXT_CTRL, 8'hA7);
    wd_stop_value <= 1'b1;
    pulse(3, 1'b1);
    rd(IDX_INT_CTRL, 8'hC4);
    check("wd stop", watchdog_stop_disable_bit, 1'b1);
    pulse(0, 1'b1);
    rd(IDX_INT_CTRL, 8'h00);
    rd(IDX_EXT_CTRL, 8'h07);
    rd(IDX_BUS_CTRL, 8'h20);
    check("filter", filter_config, 6'h00);
    check("bus ctrl", bus_control, 8'h20);
    $display("test mode_entries finished");
    rd(6'h3F, 8'h00);
    check("pslverr", last_err, 1'b1);
    $display("test unmapped finished");
    final_report();
  end
endmodule : wake_source_control_regs_bench
